/* core/fc_link_status_responder.sv */
// Purpose: answers link-status and FC statistics queries from the management_host
// Assumes: command code written over AXI4-Lite, response read back from a window
// Notes: counter events arrive as one-cycle pulses on aclk
//
// Summary of operation
// - flag per counter: cleared since last read
// - cleared flags on bits 0-8, rest zero
// - count frames, sequences, kilobytes each direction
// - count link failures, signal losses, CRC errors
// - link-status query uses command code 0x31
// - query supported only with native FC
// - accepted query answers with code 0xB1
// - fixed response layout, bytes 16 to 27
// - port-count byte equals physical ports
// - trunk status bits 0-3 per port
// - link status bits 0-3 per port
// - trunk speeds byte gives available portion
// - at most four ports, one common speed
// - trunking bonds every port, pairs or all
// - two-port trunk bonds ports 1 and 2
// - four-port: two pairs or one group
// - trunk percentages in nibbles, codes 0-4
// - channel speed codes, trunk sums members
// - statistics response uses code 0xAF
`timescale 1ns/1ps
`default_nettype none
module fc_link_status_responder #(
  parameter int NUM_PORTS = 4,
  parameter bit FC_SUPPORTED = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [fc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [fc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] port_link_up,
  input wire logic [fc_pkg::NUM_CNT-1:0] count_event
);
  import fc_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == A_CMD) || (a == A_STATUS) || (a == A_CFG) ||
              (a == A_CLEAR) || (a == A_LINK) || (a[ADDR_W-1:ADDR_W-2] == A_RESP[ADDR_W-1:ADDR_W-2]);
  endfunction

  function automatic logic [3:0] speed_sum(input logic [3:0] s, input logic [3:0] inc);
    logic [4:0] t;
    t = {1'b0, s} + {1'b0, inc};
    if (s == SPD_NONE) speed_sum = SPD_NONE;
    else if (t > {1'b0, SPD_MAX}) speed_sum = SPD_MAX;
    else speed_sum = t[3:0];
  endfunction

  function automatic logic [3:0] ones(input logic [3:0] v);
    ones = {3'b000, v[0]} + {3'b000, v[1]} + {3'b000, v[2]} + {3'b000, v[3]};
  endfunction

  localparam logic [7:0] PORTS_B = 8'(NUM_PORTS);
  localparam logic [3:0] PMASK = 4'((1 << NUM_PORTS) - 1);

  // ==========================================================
  // AXI4-Lite slave
  logic aw_hold_ff, w_hold_ff, bvalid_ff;
  logic [1:0] bresp_ff;
  logic [ADDR_W-1:0] aw_addr_ff, ar_addr_ff;
  logic [DATA_W-1:0] w_data_ff, rdata_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] rd_stage_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic do_write;
  logic [DATA_W-1:0] wmask;

  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = (rd_stage_ff == 2'b00) && !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign do_write = aw_hold_ff && w_hold_ff;
  assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= reg_hit(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // configuration and control
  logic [1:0] cfg_mode_ff;
  logic [3:0] cfg_spd_ff;
  logic cmd_go;
  logic [NUM_CNT-1:0] clr_req;
  trunk_mode_t mode;

  assign cmd_go = do_write && (aw_addr_ff == A_CMD) && w_strb_ff[0];
  assign clr_req = (do_write && (aw_addr_ff == A_CLEAR)) ? NUM_CNT'(w_data_ff & wmask) : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_mode_ff <= TRUNK_NONE;
      cfg_spd_ff <= CFG_SPD_RST;
    end
    else if (do_write && (aw_addr_ff == A_CFG) && w_strb_ff[0])
    begin
      cfg_mode_ff <= w_data_ff[CFG_MODE_LSB +: 2];
      cfg_spd_ff <= w_data_ff[CFG_SPD_LSB +: 4];
    end
  end

  // unsupported settings fall back to pairs with two ports, otherwise to no trunking
  always_comb
  begin
    mode = TRUNK_NONE;
    if (NUM_PORTS == 2 && cfg_mode_ff != 2'(TRUNK_NONE)) mode = TRUNK_PAIRS;
    else if (NUM_PORTS == 4 && cfg_mode_ff == 2'(TRUNK_PAIRS)) mode = TRUNK_PAIRS;
    else if (NUM_PORTS == 4 && cfg_mode_ff == 2'(TRUNK_ALL)) mode = TRUNK_ALL;
  end

  // ==========================================================
  // link pin synchroniser
  logic [3:0] lnk_s1_ff, lnk_s2_ff, link_up;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lnk_s1_ff <= '0;
      lnk_s2_ff <= '0;
    end
    else
    begin
      lnk_s1_ff <= port_link_up;
      lnk_s2_ff <= lnk_s1_ff;
    end
  end
  assign link_up = lnk_s2_ff & PMASK;

  // ==========================================================
  // statistics counters and cleared flags
  logic [DATA_W-1:0] cnt_ff [NUM_CNT];
  logic [NUM_CNT-1:0] cleared_ff, nxt_cleared;
  logic report_done;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++)
    begin : g_cnt
      always_ff @(posedge aclk)
      begin
        if (!aresetn || clr_req[gi])
        begin
          cnt_ff[gi] <= '0;
        end
        else if (count_event[gi])
        begin
          cnt_ff[gi] <= cnt_ff[gi] + 32'h00000001;
        end
      end
    end
  endgenerate

  // set by a clear wins over the drop after a report
  assign nxt_cleared = clr_req | (cleared_ff & ~(report_done ? {NUM_CNT{1'b1}} : '0));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cleared_ff <= '0;
    end
    else
    begin
      cleared_ff <= nxt_cleared;
    end
  end

  // ==========================================================
  // link-status fields
  logic [7:0] trunk_b, link_b, tspd_b;
  logic [7:0] ch_spd [4];
  always_comb
  begin
    trunk_b = (mode == TRUNK_NONE) ? 8'h00 : {4'h0, PMASK};
    link_b = {4'h0, link_up};
    tspd_b = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      ch_spd[i] = 8'h00;
    end
    case (mode)
      TRUNK_NONE:
      begin
        for (int i = 0; i < 4; i++)
        begin
          ch_spd[i] = link_up[i] ? {4'h0, cfg_spd_ff} : 8'h00;
        end
      end
      TRUNK_PAIRS:
      begin
        ch_spd[0] = {4'h0, speed_sum(cfg_spd_ff, 4'h1)};
        tspd_b[3:0] = ones({2'b00, link_up[1:0]}) << 1;
        if (NUM_PORTS == 4)
        begin
          ch_spd[1] = {4'h0, speed_sum(cfg_spd_ff, 4'h1)};
          tspd_b[7:4] = ones({2'b00, link_up[3:2]}) << 1;
        end
      end
      TRUNK_ALL:
      begin
        ch_spd[0] = {4'h0, speed_sum(cfg_spd_ff, 4'h2)};
        tspd_b[3:0] = ones(link_up);
      end
      default:
      begin
        tspd_b = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // response builder
  fsm_t state_ff;
  logic [7:0] code_ff;
  logic [3:0] idx_ff, len_ff;
  logic done_ff;
  logic [DATA_W-1:0] word;
  logic [3:0] len_sel;
  logic last;
  resp_mem_if #(.AW(MEM_AW), .DW(DATA_W)) mif ();

  assign len_sel = (w_data_ff[7:0] == CMD_LINK && FC_SUPPORTED) ? LEN_LINK :
                   (w_data_ff[7:0] == CMD_STATS) ? LEN_STATS : LEN_ERR;
  assign last = (state_ff == S_BUILD) && (idx_ff == len_ff - 4'h1);
  assign report_done = last && (code_ff == CMD_STATS);

  always_comb
  begin
    word = '0;
    if (code_ff == CMD_LINK && FC_SUPPORTED)
    begin
      case (idx_ff)
        4'h0: word = {8'h00, RESP_LINK, 16'h0000};
        4'h1: word = {PORTS_B, trunk_b, link_b, tspd_b};
        4'h2: word = {ch_spd[0], ch_spd[1], ch_spd[2], ch_spd[3]};
        default: word = '0;
      endcase
    end
    else if (code_ff == CMD_STATS)
    begin
      if (idx_ff == 4'h0) word = {8'h00, RESP_STATS, 16'h0000};
      else if (idx_ff == 4'h1) word = {STATS_TYPE_FC, 8'h00, 16'(cleared_ff)};
      else word = cnt_ff[idx_ff - 4'h2];
    end
    else
    begin
      word = {RC_UNSUPP, RS_UNKNOWN};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= S_IDLE;
      code_ff <= '0;
      idx_ff <= '0;
      len_ff <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        S_IDLE:
        begin
          if (cmd_go)
          begin
            state_ff <= S_BUILD;
            code_ff <= w_data_ff[7:0];
            len_ff <= len_sel;
            idx_ff <= '0;
            done_ff <= 1'b0;
          end
        end
        S_BUILD:
        begin
          idx_ff <= idx_ff + 4'h1;
          if (last)
          begin
            state_ff <= S_IDLE;
            done_ff <= 1'b1;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  assign mif.wr_en = (state_ff == S_BUILD);
  assign mif.wr_addr = idx_ff;
  assign mif.wr_data = word;
  assign mif.rd_addr = ar_addr_ff[2 +: MEM_AW];

  resp_mem #(.AW(MEM_AW), .DW(DATA_W)) u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .mp(mif.store)
  );

  // ==========================================================
  // read path: take, memory read, answer
  logic [DATA_W-1:0] reg_rd;
  always_comb
  begin
    case (ar_addr_ff)
      A_CMD: reg_rd = {24'h000000, code_ff};
      A_STATUS: reg_rd = {20'h00000, len_ff, 6'h00, done_ff, state_ff == S_BUILD};
      A_CFG: reg_rd = {24'h000000, cfg_spd_ff, 2'b00, cfg_mode_ff};
      A_LINK: reg_rd = {28'h0000000, link_up};
      default: reg_rd = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_addr_ff <= '0;
      rd_stage_ff <= 2'b00;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        ar_addr_ff <= s_axi_araddr;
        rd_stage_ff <= 2'b01;
      end
      else if (rd_stage_ff == 2'b01)
      begin
        rd_stage_ff <= 2'b10;
      end
      else if (rd_stage_ff == 2'b10)
      begin
        rd_stage_ff <= 2'b00;
        rvalid_ff <= 1'b1;
        rresp_ff <= reg_hit(ar_addr_ff) ? RESP_OKAY : RESP_SLVERR;
        if (ar_addr_ff[ADDR_W-1:ADDR_W-2] == A_RESP[ADDR_W-1:ADDR_W-2]) rdata_ff <= mif.rd_data;
        else rdata_ff <= reg_rd;
      end
      else if (rvalid_ff && s_axi_rready)
      begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_link_go;
    state_ff == S_IDLE && cmd_go && len_sel == LEN_LINK;
  endsequence
  sequence s_link_build;
    (state_ff == S_BUILD) [*3] ##1 (state_ff == S_IDLE && done_ff);
  endsequence

  a_link_len: assert property (@(posedge aclk) disable iff (!aresetn) s_link_go |=> s_link_build)
    else $error("link response length wrong");
  a_link_code: assert property (@(posedge aclk) disable iff (!aresetn)
    (mif.wr_en && code_ff == CMD_LINK && FC_SUPPORTED && idx_ff == 4'h0) |-> mif.wr_data[23:16] == RESP_LINK)
    else $error("link response code wrong");
  a_stats_code: assert property (@(posedge aclk) disable iff (!aresetn)
    (mif.wr_en && code_ff == CMD_STATS && idx_ff == 4'h0) |-> mif.wr_data[23:16] == RESP_STATS)
    else $error("stats response code wrong");
  a_link_bytes: assert property (@(posedge aclk) disable iff (!aresetn)
    (mif.wr_en && code_ff == CMD_LINK && idx_ff == 4'h1) |->
    mif.wr_data[31:24] == PORTS_B && mif.wr_data[23:20] == 4'h0 && mif.wr_data[15:12] == 4'h0)
    else $error("link status byte fields wrong");
  a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (clr_req != '0) |=> ((cleared_ff & $past(clr_req)) == $past(clr_req) && cnt_ff[0] != 32'hFFFFFFFF))
    else $error("cleared flag not set");
  a_flag_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (report_done && clr_req == '0) |=> cleared_ff == '0)
    else $error("cleared flag not dropped");
  a_cnt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_req[0] |=> cnt_ff[0] == '0)
    else $error("counter not cleared");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |-> ##3 s_axi_rvalid)
    else $error("read answer late");
endmodule // fc_link_status_responder
`default_nettype wire

/* core/fc_pkg.sv */
// Purpose: shared constants for the link-status and statistics responder
// Assumes: AXI4-Lite with 32-bit data, byte addresses
// Notes: response words are indexed from packet byte 16
package fc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CNT = 9;
  localparam int MEM_AW = 4;
  // ==========================================================
  // command and response codes
  localparam logic [7:0] CMD_LINK = 8'h31;
  localparam logic [7:0] CMD_STATS = 8'h2F;
  localparam logic [7:0] RESP_LINK = 8'hB1;
  localparam logic [7:0] RESP_STATS = 8'hAF;
  localparam logic [15:0] RC_UNSUPP = 16'h0001;
  localparam logic [15:0] RS_UNKNOWN = 16'h0001;
  localparam logic [7:0] STATS_TYPE_FC = 8'h02;
  localparam logic [3:0] LEN_LINK = 4'h3;
  localparam logic [3:0] LEN_STATS = 4'hB;
  localparam logic [3:0] LEN_ERR = 4'h1;
  // ==========================================================
  // register map
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_CFG = 8'h08;
  localparam logic [7:0] A_CLEAR = 8'h0C;
  localparam logic [7:0] A_LINK = 8'h10;
  localparam logic [7:0] A_RESP = 8'h40;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_LEN_LSB = 8;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SPD_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ==========================================================
  // field encodings
  localparam logic [3:0] SPD_NONE = 4'h0;
  localparam logic [3:0] SPD_MAX = 4'h8;
  localparam logic [3:0] CFG_SPD_RST = 4'h0;
  typedef enum logic [1:0] {
    TRUNK_NONE = 2'b00,
    TRUNK_PAIRS = 2'b01,
    TRUNK_ALL = 2'b10
  } trunk_mode_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_BUILD = 2'b01
  } fsm_t;
endpackage

/* core/resp_mem_if.sv */
// Purpose: carrier between the responder and its response store
// Assumes: single clock, registered read port
// Notes: one write port, one read port
`timescale 1ns/1ps
`default_nettype none
interface resp_mem_if #(parameter int AW = 4, parameter int DW = 32);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport writer (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* core/resp_mem.sv */
// Purpose: holds the words of the last response packet
// Assumes: one clock, synchronous active-low reset
// Notes: read data come from a register, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module resp_mem #(parameter int AW = 4, parameter int DW = 32) (
  input wire logic aclk,
  input wire logic aresetn,
  resp_mem_if.store mp
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rd_ff;

  always_ff @(posedge aclk)
  begin
    if (mp.wr_en)
    begin
      mem_q[mp.wr_addr] <= mp.wr_data;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_ff <= '0;
    end
    else
    begin
      rd_ff <= mem_q[mp.rd_addr];
    end
  end

  assign mp.rd_data = rd_ff;
endmodule // resp_mem
`default_nettype wire

/* testbench/mgmt_host_model.sv */
// Purpose: management_host side, AXI4-Lite master with blocking access tasks
// Assumes: one write and one read at a time, aclk rising edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
  input wire logic aclk,
  output var logic [fc_pkg::ADDR_W-1:0] s_axi_awaddr,
  output var logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output var logic [fc_pkg::DATA_W-1:0] s_axi_wdata,
  output var logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output var logic s_axi_bready,
  output var logic [fc_pkg::ADDR_W-1:0] s_axi_araddr,
  output var logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [fc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output var logic s_axi_rready
);
  import fc_pkg::*;
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // ==========================================================
  // write: address and data offered together, each released when taken
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // ==========================================================
  // read: data taken at the edge where rvalid is seen
  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule // mgmt_host_model
`default_nettype wire

/* testbench/test_fc_link_status_responder.sv */
// Purpose: register-level test of the link-status and statistics responder
// Assumes: four ports, native FC enabled, full-word writes
// Notes: all traffic goes through the host model tasks
`timescale 1ns/1ps
`default_nettype none
module test_fc_link_status_responder;
  import fc_pkg::*;
  logic aclk;
  logic aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, port_link_up;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [NUM_CNT-1:0] count_event;
  logic [DATA_W-1:0] exp_cnt [NUM_CNT];
  int n_errors;
  int cmp_count;
  // link cases: mode, speed, links, word 1, word 2
  logic [1:0] c_mode [5] = '{TRUNK_NONE, TRUNK_PAIRS, TRUNK_ALL, TRUNK_ALL, TRUNK_PAIRS};
  logic [3:0] c_spd [5] = '{4'h5, 4'h3, 4'h7, 4'h2, 4'h8};
  logic [3:0] c_link [5] = '{4'hB, 4'h7, 4'hF, 4'h5, 4'hE};
  logic [31:0] c_w1 [5] = '{32'h04000B00, 32'h040F0724, 32'h040F0F04, 32'h040F0502, 32'h040F0E42};
  logic [31:0] c_w2 [5] = '{32'h05050005, 32'h04040000, 32'h08000000, 32'h04000000, 32'h08080000};
  assign s_axi_wstrb = 4'hF;
  fc_link_status_responder #(.NUM_PORTS(4), .FC_SUPPORTED(1'b1)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_link_up, .count_event
  );
  mgmt_host_model u_host (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic [1:0] er);
    logic [DATA_W-1:0] d;
    logic [1:0] r;
    u_host.bus_read(a, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, er});
  endtask
  task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_host.bus_write(a, d, r);
    check({30'h0, r}, {30'h0, er});
  endtask
  task automatic run_cmd(input logic [7:0] code, input logic [3:0] len);
    logic [DATA_W-1:0] st;
    logic [1:0] r;
    int k;
    wr_chk(A_CMD, {24'h0, code}, RESP_OKAY);
    st = '0;
    k = 0;
    while (!(st[ST_DONE] === 1'b1 && st[ST_BUSY] === 1'b0) && k < 40)
    begin
      u_host.bus_read(A_STATUS, st, r);
      k++;
    end
    check({30'h0, st[ST_DONE], st[ST_BUSY]}, 32'h00000002);
    check({28'h0, st[ST_LEN_LSB +: 4]}, {28'h0, len});
  endtask
  task automatic pulse(input int b, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      count_event <= NUM_CNT'(1) << b;
      @(posedge aclk);
      count_event <= '0;
    end
  endtask
  task automatic stats_chk(input logic [8:0] flags);
    run_cmd(CMD_STATS, LEN_STATS);
    rd_chk(A_RESP, {8'h00, RESP_STATS, 16'h0000}, RESP_OKAY);
    rd_chk(A_RESP + 8'h04, {STATS_TYPE_FC, 8'h00, 7'h00, flags}, RESP_OKAY);
    for (int i = 0; i < NUM_CNT; i++)
      rd_chk(A_RESP + 8'(8 + 4 * i), exp_cnt[i], RESP_OKAY);
  endtask
  task automatic finish_test();
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #800000;
    n_errors++;
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    n_errors = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    port_link_up = 4'h0;
    count_event = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(A_CFG, 32'h0, RESP_OKAY);
    rd_chk(A_STATUS, 32'h0, RESP_OKAY);
    rd_chk(A_CLEAR, 32'h0, RESP_OKAY);
    rd_chk(8'h14, 32'h0, RESP_SLVERR);
    wr_chk(8'h20, 32'hFFFFFFFF, RESP_SLVERR);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge aclk);
      port_link_up <= c_link[i];
      wr_chk(A_CFG, (32'(c_spd[i]) << CFG_SPD_LSB) | (32'(c_mode[i]) << CFG_MODE_LSB), RESP_OKAY);
      rd_chk(A_CFG, (32'(c_spd[i]) << CFG_SPD_LSB) | (32'(c_mode[i]) << CFG_MODE_LSB), RESP_OKAY);
      rd_chk(A_LINK, {28'h0, c_link[i]}, RESP_OKAY);
      run_cmd(CMD_LINK, LEN_LINK);
      rd_chk(A_RESP, {8'h00, RESP_LINK, 16'h0000}, RESP_OKAY);
      rd_chk(A_RESP + 8'h04, c_w1[i], RESP_OKAY);
      rd_chk(A_RESP + 8'h08, c_w2[i], RESP_OKAY);
    end
    for (int i = 0; i < NUM_CNT; i++)
    begin
      exp_cnt[i] = DATA_W'(i + 1);
      pulse(i, i + 1);
    end
    stats_chk(9'h000);
    wr_chk(A_CLEAR, 32'h00000105, RESP_OKAY);
    exp_cnt[0] = 32'h1;
    exp_cnt[2] = 32'h0;
    exp_cnt[8] = 32'h0;
    pulse(0, 1);
    stats_chk(9'h105);
    stats_chk(9'h000);
    run_cmd(8'h55, LEN_ERR);
    rd_chk(A_RESP, {RC_UNSUPP, RS_UNKNOWN}, RESP_OKAY);
    rd_chk(A_CMD, 32'h00000055, RESP_OKAY);
    // command during a build is ignored
    wr_chk(A_CMD, {24'h0, CMD_STATS}, RESP_OKAY);
    wr_chk(A_CMD, {24'h0, CMD_LINK}, RESP_OKAY);
    rd_chk(A_CMD, {24'h0, CMD_STATS}, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd_chk(A_RESP, {8'h00, RESP_STATS, 16'h0000}, RESP_OKAY);
    // reset in mid-run clears settings, counters and flags
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(A_CFG, 32'h0, RESP_OKAY);
    rd_chk(A_STATUS, 32'h0, RESP_OKAY);
    for (int i = 0; i < NUM_CNT; i++)
    begin
      exp_cnt[i] = '0;
    end
    stats_chk(9'h000);
    finish_test();
  end
endmodule // test_fc_link_status_responder
`default_nettype wire
